//--- tcsw_timer.sv
// capture/compare timer with square-wave output, apb register slave
// assumes inputs synchronous to pclk; count clock from a pclk prescaler
`timescale 1ns/1ns
`include "tcsw_consts.svh"

module tcsw_timer (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        timer_input_a,
   input  wire logic        timer_input_b,
   output logic             timer_output_pin,
   output logic             timer_output_oe,
   output logic             irq
);
   tcsw_pkg::tcsw_state_t s_q;
   tcsw_pkg::tcsw_state_t s_d;

   // edge match for a two-bit edge select
   function automatic logic edge_hit(input logic [1:0] es,
                                     input logic rose, input logic fell);
      case (es)
         `TCSW_ES_FALL: edge_hit = fell;
         `TCSW_ES_RISE: edge_hit = rose;
         `TCSW_ES_BOTH: edge_hit = rose | fell;
         default:       edge_hit = 1'b0;
      endcase
   endfunction

   function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
      hit = (a == b);
   endfunction

   logic                 wr;
   logic                 mapped;
   logic                 tick;
   logic                 a_rose;
   logic                 a_fell;
   logic                 b_rose;
   logic                 b_fell;
   logic                 a_edge;
   logic                 a_opp;
   logic                 b_edge;
   logic                 match_a;
   logic [1:0]           esa;
   tcsw_pkg::tcsw_mode_t mode;

   always_comb begin
      mode   = tcsw_pkg::tcsw_mode_t'(s_q.tmc_q[`TCSW_TMC_LO +: 2]);
      esa    = s_q.prm_q[`TCSW_PRM_ESA +: 2];
      wr     = psel & penable & pwrite & clk_en;
      mapped = hit(paddr, `TCSW_A_TMC) | hit(paddr, `TCSW_A_CRC)
             | hit(paddr, `TCSW_A_TOC) | hit(paddr, `TCSW_A_PRM)
             | hit(paddr, `TCSW_A_CNT) | hit(paddr, `TCSW_A_CCA)
             | hit(paddr, `TCSW_A_CCB) | hit(paddr, `TCSW_A_STAT)
             | hit(paddr, `TCSW_A_MASK);
      // count clock: pclk divided by 1, 4, 16 or 256 for sel 0 to 3
      case (s_q.prm_q[`TCSW_PRM_CK +: 2])
         2'h0:    tick = 1'b1;
         2'h1:    tick = s_q.div_q[1:0] == 2'h3;
         2'h2:    tick = s_q.div_q[3:0] == 4'hf;
         default: tick = s_q.div_q == 8'hff;
      endcase
      tick = tick & clk_en;
      // level taken only when two samples agree
      a_rose = tick & s_q.sa_q[0] & s_q.sa_q[1] & ~s_q.lva_q;
      a_fell = tick & ~s_q.sa_q[0] & ~s_q.sa_q[1] & s_q.lva_q;
      b_rose = tick & s_q.sb_q[0] & s_q.sb_q[1] & ~s_q.lvb_q;
      b_fell = tick & ~s_q.sb_q[0] & ~s_q.sb_q[1] & s_q.lvb_q;
      a_edge = (mode != tcsw_pkg::TCSW_STOP) & edge_hit(esa, a_rose, a_fell);
      // opposite edge exists only for single-edge selections
      a_opp  = (mode != tcsw_pkg::TCSW_STOP) & (esa != `TCSW_ES_BOTH)
             & edge_hit(esa, a_fell, a_rose);
      b_edge = (mode != tcsw_pkg::TCSW_STOP)
             & edge_hit(s_q.prm_q[`TCSW_PRM_ESB +: 2], b_rose, b_fell);
      match_a = tick & (s_q.cnt_q == s_q.cca_q);

      s_d = s_q;
      if (tick) begin
         s_d.sa_q = {s_q.sa_q[0], timer_input_a};
         s_d.sb_q = {s_q.sb_q[0], timer_input_b};
         if (a_rose | a_fell)
            s_d.lva_q = s_q.sa_q[1];
         if (b_rose | b_fell)
            s_d.lvb_q = s_q.sb_q[1];
      end
      if (clk_en)
         s_d.div_q = s_q.div_q + 8'h01;

      // counter
      if (tick & (mode != tcsw_pkg::TCSW_STOP)) begin
         s_d.cnt_q = s_q.cnt_q + 16'h0001;
         if (s_q.cnt_q == 16'hffff)
            s_d.stat_q[`TCSW_ST_OVF] = 1'b1;
      end
      if ((mode == tcsw_pkg::TCSW_CLR) & match_a) begin
         s_d.cnt_q = 16'h0000;
         s_d.stat_q[`TCSW_ST_A] = 1'b1;
         if (s_q.toc_q[`TCSW_TOC_OE] & s_q.toc_q[`TCSW_TOC_TGL])
            s_d.out_q = ~s_q.out_q;
      end

      // captures on input a
      if (a_edge) begin
         s_d.ccb_q = s_q.cnt_q;
         s_d.stat_q[`TCSW_ST_B] = 1'b1;
         if (mode == tcsw_pkg::TCSW_RSTRT)
            s_d.cnt_q = 16'h0000;
      end
      if (a_opp & s_q.crc_q[`TCSW_CRC_A_CAP] & s_q.crc_q[`TCSW_CRC_SRC])
         s_d.cca_q = s_q.cnt_q;
      // input b into register a unless source select redirects
      if (b_edge & s_q.crc_q[`TCSW_CRC_A_CAP]) begin
         if (!s_q.crc_q[`TCSW_CRC_SRC])
            s_d.cca_q = s_q.cnt_q;
         s_d.stat_q[`TCSW_ST_A] = 1'b1;
      end

      // apb writes; hardware set of a clear flag wins over write-one clear
      if (wr) begin
         if (hit(paddr, `TCSW_A_TMC))  s_d.tmc_q = pwdata[7:0];
         if (hit(paddr, `TCSW_A_CRC))  s_d.crc_q = pwdata[7:0];
         if (hit(paddr, `TCSW_A_TOC))  s_d.toc_q = pwdata[7:0];
         if (hit(paddr, `TCSW_A_PRM))  s_d.prm_q = pwdata[7:0];
         if (hit(paddr, `TCSW_A_CCA))  s_d.cca_q = pwdata[15:0];
         if (hit(paddr, `TCSW_A_CCB))  s_d.ccb_q = pwdata[15:0];
         if (hit(paddr, `TCSW_A_MASK)) s_d.mask_q = pwdata[2:0];
         if (hit(paddr, `TCSW_A_STAT))
            s_d.stat_q = s_d.stat_q & ~(pwdata[2:0] & ~(s_d.stat_q
                       & ~s_q.stat_q));
         if (hit(paddr, `TCSW_A_TMC) &&
             pwdata[`TCSW_TMC_LO +: 2] == 2'h0)
            s_d.cnt_q = 16'h0000;
      end
      if (psel & ~penable & ~pwrite & clk_en) begin
         s_d.rdata_q = 32'h0000_0000;
         if (hit(paddr, `TCSW_A_TMC))  s_d.rdata_q[7:0]  = s_q.tmc_q;
         if (hit(paddr, `TCSW_A_CRC))  s_d.rdata_q[7:0]  = s_q.crc_q;
         if (hit(paddr, `TCSW_A_TOC))  s_d.rdata_q[7:0]  = s_q.toc_q;
         if (hit(paddr, `TCSW_A_PRM))  s_d.rdata_q[7:0]  = s_q.prm_q;
         if (hit(paddr, `TCSW_A_CNT))  s_d.rdata_q[15:0] = s_q.cnt_q;
         if (hit(paddr, `TCSW_A_CCA))  s_d.rdata_q[15:0] = s_q.cca_q;
         if (hit(paddr, `TCSW_A_CCB))  s_d.rdata_q[15:0] = s_q.ccb_q;
         if (hit(paddr, `TCSW_A_STAT)) s_d.rdata_q[2:0]  = s_q.stat_q;
         if (hit(paddr, `TCSW_A_MASK)) s_d.rdata_q[2:0]  = s_q.mask_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata           = s_q.rdata_q;
   assign pready           = clk_en;
   assign pslverr          = psel & penable & ~mapped;
   assign timer_output_pin = s_q.out_q;
   assign timer_output_oe  = s_q.toc_q[`TCSW_TOC_OE];
   assign irq              = |(s_q.stat_q & s_q.mask_q);

   // assertions
   property p_cap_b;
      @(posedge pclk) disable iff (!presetn)
      (a_edge && !wr) |=> (s_q.ccb_q == $past(s_q.cnt_q)) && s_q.stat_q[1];
   endproperty
   a_cap_b: assert property (p_cap_b) else $error("b capture missed");

   property p_filter;
      @(posedge pclk) disable iff (!presetn)
      (a_rose && s_q.prm_q[1:0] == 2'h0)
      |-> $past(timer_input_a, 1) && $past(timer_input_a, 2);
   endproperty
   a_filter: assert property (p_filter) else $error("unfiltered edge");

   property p_ovf;
      @(posedge pclk) disable iff (!presetn)
      (tick && mode == tcsw_pkg::TCSW_FREE && s_q.cnt_q == 16'hffff && !a_edge)
      |=> s_q.stat_q[2] && s_q.cnt_q == 16'h0000;
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow not flagged");

   property p_cap_a;
      @(posedge pclk) disable iff (!presetn)
      (b_edge && s_q.crc_q[0] && !s_q.crc_q[1] && !wr)
      |=> s_q.cca_q == $past(s_q.cnt_q) && s_q.stat_q[0];
   endproperty
   a_cap_a: assert property (p_cap_a) else $error("a capture missed");

   property p_src;
      @(posedge pclk) disable iff (!presetn)
      (b_edge && s_q.crc_q[0] && s_q.crc_q[1] && !a_opp && !wr)
      |=> $stable(s_q.cca_q) && s_q.stat_q[0];
   endproperty
   a_src: assert property (p_src) else $error("source select broken");

   property p_both;
      @(posedge pclk) disable iff (!presetn)
      (esa == 2'h3 && !b_edge && !wr) |=> $stable(s_q.cca_q);
   endproperty
   a_both: assert property (p_both) else $error("both-edge load a");

   property p_rst;
      @(posedge pclk) disable iff (!presetn)
      (a_edge && mode == tcsw_pkg::TCSW_RSTRT && !wr) |=> s_q.cnt_q == 16'h0;
   endproperty
   a_rst: assert property (p_rst) else $error("restart not cleared");

   property p_tgl;
      @(posedge pclk) disable iff (!presetn)
      (match_a && mode == tcsw_pkg::TCSW_CLR && s_q.toc_q[1:0] == 2'h3)
      |=> timer_output_pin != $past(timer_output_pin) && s_q.stat_q[0];
   endproperty
   a_tgl: assert property (p_tgl) else $error("no toggle on match");

   property p_hold;
      @(posedge pclk) disable iff (!presetn)
      (mode == tcsw_pkg::TCSW_STOP && !wr) |=> $stable(s_q.cnt_q);
   endproperty
   a_hold: assert property (p_hold) else $error("counter moved");

   property p_inc;
      @(posedge pclk) disable iff (!presetn)
      (tick && mode == tcsw_pkg::TCSW_FREE && !a_edge && !wr)
      |=> s_q.cnt_q == $past(s_q.cnt_q) + 16'h0001;
   endproperty
   a_inc: assert property (p_inc) else $error("counter not stepped");

   property p_freeze;
      @(posedge pclk) disable iff (!presetn)
      !clk_en |=> $stable(s_q);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved");

   property p_rst_irq;
      @(posedge pclk) disable iff (!presetn)
      (a_edge && mode == tcsw_pkg::TCSW_RSTRT) |=> s_q.stat_q[1];
   endproperty
   a_rst_irq: assert property (p_rst_irq) else $error("no b irq");

   property p_opp;
      @(posedge pclk) disable iff (!presetn)
      (a_opp && s_q.crc_q[1:0] == 2'h3 && !wr)
      |=> s_q.cca_q == $past(s_q.cnt_q);
   endproperty
   a_opp_cap: assert property (p_opp) else $error("opposite edge lost");
endmodule // tcsw_timer

//--- tcsw_consts.svh
// constants for the capture/compare and square-wave timer block
// assumes an apb master on pclk; registers are one aligned word each
// Summary of operation
// - free-running, input a valid edge copies counter into b, raises b irq.
// - inputs sampled on count clock; new level must be seen twice.
// - counter wrap past maximum sets the overflow flag.
// - input b valid edge copies counter into a, raises a irq.
// - two-register mode: selected edge loads b, opposite edge loads a.
// - input a set to both edges never loads register a.
// - source select set: input b edge raises a irq without loading a.
// - restart mode: input a edge captures into b then clears counter.
// - restart mode edge is rising or falling via edge select bits.
// - clear-and-start with output enable and toggle set: pin inverts every compare+1 clocks.
// - clear-and-start: counter equal to a clears it and raises a irq.
`ifndef TCSW_CONSTS_SVH
`define TCSW_CONSTS_SVH
`define TCSW_A_TMC      12'h000
`define TCSW_A_CRC      12'h004
`define TCSW_A_TOC      12'h008
`define TCSW_A_PRM      12'h00c
`define TCSW_A_CNT      12'h010
`define TCSW_A_CCA      12'h014
`define TCSW_A_CCB      12'h018
`define TCSW_A_STAT     12'h01c
`define TCSW_A_MASK     12'h020
// mode control bits 3:2
`define TCSW_TMC_LO     2
`define TCSW_TMC_FREE   2'h1
`define TCSW_TMC_RSTRT  2'h2
`define TCSW_TMC_CLR    2'h3
// capture control bits
`define TCSW_CRC_A_CAP  0
`define TCSW_CRC_SRC    1
`define TCSW_CRC_B_CAP  2
// output control bits
`define TCSW_TOC_OE     0
`define TCSW_TOC_TGL    1
// prescaler bits
`define TCSW_PRM_CK     0
`define TCSW_PRM_ESA    4
`define TCSW_PRM_ESB    6
`define TCSW_ES_FALL    2'h0
`define TCSW_ES_RISE    2'h1
`define TCSW_ES_BOTH    2'h3
// status bits
`define TCSW_ST_A       0
`define TCSW_ST_B       1
`define TCSW_ST_OVF     2
`define TCSW_ST_W       3
`endif

//--- tcsw_pkg.sv
// types for the capture/compare and square-wave timer block
// assumes tcsw_consts.svh for all numeric values
package tcsw_pkg;
   typedef enum logic [1:0] {
      TCSW_STOP  = 2'b00,
      TCSW_FREE  = 2'b01,
      TCSW_RSTRT = 2'b10,
      TCSW_CLR   = 2'b11
   } tcsw_mode_t;

   typedef struct packed {
      logic [7:0]  tmc_q;
      logic [7:0]  crc_q;
      logic [7:0]  toc_q;
      logic [7:0]  prm_q;
      logic [15:0] cnt_q;
      logic [15:0] cca_q;
      logic [15:0] ccb_q;
      logic [2:0]  stat_q;
      logic [2:0]  mask_q;
      logic [7:0]  div_q;
      logic [1:0]  sa_q;
      logic [1:0]  sb_q;
      logic        lva_q;
      logic        lvb_q;
      logic        out_q;
      logic [31:0] rdata_q;
   } tcsw_state_t;
endpackage

//--- tcsw_pulse_src.sv
// far-side pulse source on the two timer input pins
// assumes tasks are called right after a rising pclk edge
`timescale 1ns/1ns

module tcsw_pulse_src (
   input  wire logic pclk,
   output logic      sig_a,
   output logic      sig_b
);
   initial begin
      sig_a = 1'b0;
      sig_b = 1'b0;
   end
   // both pins act as timer inputs
   task automatic set(input logic a, input logic b);
      sig_a <= a;
      sig_b <= b;
   endtask
   // pulse train, widths under one counter period
   task automatic train(input logic ua, input logic ub, input int hi,
                        input int lo, input int n);
      repeat (n) begin
         set(ua, ub);
         repeat (hi) @(posedge pclk);
         set(1'b0, 1'b0);
         repeat (lo) @(posedge pclk);
      end
   endtask
endmodule // tcsw_pulse_src

//--- tcsw_timer_tb.sv
// bench for the timer: apb tasks, capture and square-wave scenarios
// assumes tcsw_timer and tcsw_pulse_src; count clock divider is 1
`timescale 1ns/1ns
`include "tcsw_consts.svh"

module tcsw_timer_tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        tin_a, tin_b, tout, toe, irq, err_q, tmp, en;
   logic [15:0] v1, v2;
   int          n_mismatch, num_checks, cyc, seed, w, l, n;

   tcsw_timer dut (.pclk(pclk), .presetn(presetn), .clk_en(en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timer_input_a(tin_a), .timer_input_b(tin_b),
      .timer_output_pin(tout), .timer_output_oe(toe), .irq(irq));
   tcsw_pulse_src src (.pclk(pclk), .sig_a(tin_a), .sig_b(tin_b));

   initial pclk = 1'b0;
   always #2 pclk = ~pclk;

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 98000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd    = prdata;
      err_q = pslverr;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      penable <= 1'b0;
      psel    <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rdr(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
      penable <= 1'b0;
      psel    <= 1'b0;
      @(posedge pclk);
   endtask
   function automatic logic [31:0] md(input logic [1:0] m);
      return 32'(m) << `TCSW_TMC_LO;
   endfunction
   function automatic logic [31:0] pr(input logic [1:0] ea, input logic [1:0] eb);
      return (32'(eb) << `TCSW_PRM_ESB) | (32'(ea) << `TCSW_PRM_ESA);
   endfunction
   task automatic cnt2();
      apb(1'b0, `TCSW_A_CNT, 32'h0);
      v1 = rd[15:0];
      rdr(`TCSW_A_CNT);
      v2 = rd[15:0];
   endtask

   initial begin
      seed = 32'hc2cc;
      {presetn, en, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      en      <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 9; i++) begin
         rdr(12'(i * 4));
         chk(rd, 32'h0);
      end
      rdr(12'h024);
      chk({rd[30:0], err_q}, 32'h1);
      cnt2();
      chk(32'(16'(v2 - v1)), 32'h0);
      wr(`TCSW_A_CRC, 32'h0);
      wr(`TCSW_A_PRM, pr(`TCSW_ES_BOTH, `TCSW_ES_RISE));
      wr(`TCSW_A_TMC, md(tcsw_pkg::TCSW_FREE));
      cnt2();
      chk(32'(16'(v2 - v1)), 32'h2);
      rdr(`TCSW_A_CNT);
      v1 = rd[15:0];
      en <= 1'b0;
      repeat (5) @(posedge pclk);
      en <= 1'b1;
      rdr(`TCSW_A_CNT);
      v2 = rd[15:0];
      chk(32'(16'(v2 - v1)), 32'h3);
      wr(`TCSW_A_MASK, 32'h2);
      w = 30 + ($unsigned($random(seed)) % 100);
      src.set(1'b1, 1'b0);
      repeat (8) @(posedge pclk);
      rdr(`TCSW_A_CCB);
      v1 = rd[15:0];
      repeat (w - 11) @(posedge pclk);
      src.set(1'b0, 1'b0);
      repeat (8) @(posedge pclk);
      rdr(`TCSW_A_CCB);
      v2 = rd[15:0];
      chk(32'(16'(v2 - v1)), 32'(w));
      chk({31'h0, irq}, 32'h1);
      wr(`TCSW_A_STAT, 32'h7);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      src.train(1'b1, 1'b0, 1, 10, 1);
      rdr(`TCSW_A_CCB);
      chk(rd, {16'h0, v2});
      wr(`TCSW_A_MASK, 32'h0);
      src.train(1'b1, 1'b0, 10, 10, 1);
      rdr(`TCSW_A_STAT);
      chk({30'h0, irq, rd[1]}, 32'h1);
      wr(`TCSW_A_CRC, 32'h1);
      wr(`TCSW_A_PRM, pr(`TCSW_ES_RISE, `TCSW_ES_RISE));
      wr(`TCSW_A_STAT, 32'h7);
      src.train(1'b1, 1'b1, 10, 10, 1);
      rdr(`TCSW_A_CCA);
      v1 = rd[15:0];
      rdr(`TCSW_A_CCB);
      chk(rd, {16'h0, v1});
      rdr(`TCSW_A_STAT);
      chk({30'h0, rd[1:0]}, 32'h3);
      wr(`TCSW_A_CRC, 32'h3);
      wr(`TCSW_A_STAT, 32'h7);
      src.train(1'b0, 1'b1, 10, 10, 1);
      rdr(`TCSW_A_CCA);
      chk(rd, {16'h0, v1});
      rdr(`TCSW_A_STAT);
      chk({31'h0, rd[0]}, 32'h1);
      w = 10 + ($unsigned($random(seed)) % 200);
      src.train(1'b1, 1'b0, w, 10, 1);
      rdr(`TCSW_A_CCB);
      v1 = rd[15:0];
      rdr(`TCSW_A_CCA);
      v2 = rd[15:0];
      chk(32'(16'(v2 - v1)), 32'(w));
      wr(`TCSW_A_PRM, pr(`TCSW_ES_BOTH, 2'h0));
      src.train(1'b1, 1'b0, 10, 10, 1);
      rdr(`TCSW_A_CCA);
      chk(rd, {16'h0, v2});
      wr(`TCSW_A_STAT, 32'h7);
      repeat (65536) @(posedge pclk);
      rdr(`TCSW_A_STAT);
      chk({31'h0, rd[2]}, 32'h1);
      for (int e = 0; e < 2; e++) begin
         wr(`TCSW_A_CRC, 32'h0);
         wr(`TCSW_A_PRM, pr(e ? `TCSW_ES_FALL : `TCSW_ES_RISE, 2'h0));
         wr(`TCSW_A_TMC, md(tcsw_pkg::TCSW_RSTRT));
         wr(`TCSW_A_STAT, 32'h7);
         w = 5 + ($unsigned($random(seed)) % 40);
         l = 5 + ($unsigned($random(seed)) % 40);
         src.train(1'b1, 1'b0, w, l, 2);
         rdr(`TCSW_A_CCB);
         chk(rd, 32'(w + l - 1));
         rdr(`TCSW_A_STAT);
         chk({31'h0, rd[1]}, 32'h1);
      end
      wr(`TCSW_A_TMC, 32'h0);
      wr(`TCSW_A_PRM, 32'h0);
      wr(`TCSW_A_CRC, 32'h0);
      wr(`TCSW_A_TOC, 32'h3);
      n = 3 + ($unsigned($random(seed)) % 30);
      wr(`TCSW_A_CCA, 32'(n));
      wr(`TCSW_A_STAT, 32'h7);
      wr(`TCSW_A_TMC, md(tcsw_pkg::TCSW_CLR));
      chk({31'h0, toe}, 32'h1);
      for (int k = 0; k < 2; k++) begin
         tmp = tout;
         w = 0;
         while (tout === tmp && w < 200) begin
            @(posedge pclk);
            w++;
         end
      end
      chk(32'(w), 32'(n + 1));
      rdr(`TCSW_A_STAT);
      chk({31'h0, rd[0]}, 32'h1);
      rdr(`TCSW_A_CNT);
      chk({31'h0, rd <= 32'(n)}, 32'h1);
      tally_and_finish();
   end
endmodule // tcsw_timer_tb
